// [design/crc_gen_pkg.sv]
// constants shared by the programmable crc generator
// assumes a 32-bit avalon-mm slave with word addressing by byte address
package crc_gen_pkg;
	// register byte offsets
	localparam logic [4:0] OFS_CONTROL_ONE = 5'h00;
	localparam logic [4:0] OFS_CONTROL_TWO = 5'h04;
	localparam logic [4:0] OFS_POLY_TERMS_LOW = 5'h08;
	localparam logic [4:0] OFS_POLY_TERMS_HIGH = 5'h0C;
	localparam logic [4:0] OFS_FIFO_IN_LOW = 5'h10;
	localparam logic [4:0] OFS_FIFO_IN_HIGH = 5'h14;
	localparam logic [4:0] OFS_RESULT_LOW = 5'h18;
	localparam logic [4:0] OFS_RESULT_HIGH = 5'h1C;
	// control_one field positions
	localparam int BIT_MODULE_ENABLE = 15;
	localparam int BIT_IDLE_STOP = 13;
	localparam int BIT_COUNT_LSB = 8;
	localparam int BIT_FULL = 7;
	localparam int BIT_EMPTY = 6;
	localparam int BIT_IRQ_SEL = 5;
	localparam int BIT_START = 4;
	localparam int BIT_LSB_FIRST = 3;
	// control_two field positions
	localparam int BIT_WIDTH_LSB = 8;
	localparam int BIT_POLY_LENGTH_SEL_LSB = 0;
	// fifo depths by width band
	localparam logic [4:0] DEPTH_WIDE = 5'h04;
	localparam logic [4:0] DEPTH_MID = 5'h08;
	localparam logic [4:0] DEPTH_NARROW = 5'h10;
	localparam logic [4:0] WIDTH_MID_MIN = 5'h08;
	localparam logic [4:0] WIDTH_WIDE_MIN = 5'h10;
	localparam int FIFO_SLOTS = 16;
	localparam logic [5:0] BITS_PER_CYCLE = 6'h02;
	// reset values
	localparam logic [15:0] RST_HALF = 16'h0000;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage

// [design/crc_gen.sv]
// programmable crc generator with data fifo and two-bit-per-cycle engine
// assumes an avalon-mm master on i_clk; byte enables select register lanes
//
// Decided for this implementation: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
// How it works
// (RL1) polynomial order up to 32, length field holds highest exponent minus one
// (RL2) each set term bit inserts feedback xor at that engine bit
// (RL3) zero-order term always xored; its bit is not stored
// (RL4) order-n term always used; no storage bit for order 32
// (RL5) data width programmable 1 to 32 bits, independent of polynomial length
// (RL6) fifo depth 4 above width field 15, 8 for 8..15, 16 below 8
// (RL7) fifo takes byte writes; bits above configured width are dropped
// (RL8) count increments when byte holding width msb is written
// (RL9) software writes low data half before high half
// (RL10) while started with words pending, move word to buffer and decrement count
// (RL11) shift two bits per cycle until fifo drained, then clear start
// (RL12) full flag set when count equals depth for current width
// (RL13) empty flag set when count is zero
// (RL14) enable low empties fifo and forces count to zero
// (RL15) software waits a cycle after data write before reading count
// (RL16) direction zero shifts msb first, one shifts lsb first
// (RL17) direction only changes input order; result is a normal crc
// (RL18) irq select zero: interrupt on count going from one to zero
// (RL19) irq select one: interrupt on hardware start clear only
// (RL20) software enables, configures, preloads, clears result, starts, refills, reads
// (RL21) polynomial length is length field plus one
// (RL22) data width is width field plus one
// (RL23) enable low resets engine, pointers, data and result; config kept
// (RL24) result pair is the working shift register and initial remainder
module crc_gen
	import crc_gen_pkg::*;
#(
	parameter int ADDR_W = 5
)
(
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [ADDR_W-1:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [3:0] i_byteenable,
	input wire logic [31:0] i_writedata,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	output logic o_crc_irq
);
	// refuse an address bus too narrow to reach the register map
	if (ADDR_W < 5)
	begin : g_addr_check
		$error("ADDR_W must be at least 5");
	end

	// merge a written half word under its two byte enables
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] nw,
		input logic [1:0] be);
		merge16 = {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
	endfunction

	// mask of n+1 low ones
	function automatic logic [31:0] low_mask(input logic [4:0] n);
		low_mask = 32'hFFFF_FFFF >> (5'd31 - n);
	endfunction

	// one crc step: feedback from top bit of order n, poly taps below it
	function automatic logic [31:0] crc_bit(input logic [31:0] r, input logic d,
		input logic [31:0] taps, input logic [4:0] n);
		logic fb;
		logic [31:0] sh;
		fb = r[n] ^ d;
		sh = {r[30:0], 1'b0} & low_mask(n);
		crc_bit = fb ? (sh ^ taps) : sh;
	endfunction

	logic ack_reg;
	logic enable_reg;
	logic idle_stop_reg;
	logic irq_sel_reg;
	logic start_reg;
	logic lsb_first_reg;
	logic [4:0] width_sel_reg;
	logic [4:0] poly_length_sel_sel_reg;
	logic [31:1] poly_reg;
	logic [31:0] hold_reg;
	logic [31:0] result_reg;
	logic [31:0] fifo_mem [FIFO_SLOTS];
	logic [3:0] wr_ptr_reg;
	logic [3:0] rd_ptr_reg;
	logic [4:0] count_reg;
	logic busy_reg;
	logic [31:0] shift_reg;
	logic [5:0] left_reg;
	logic irq_reg;
	logic [31:0] readdata_reg;

	// bus handshake: one wait cycle, accepted on the second edge
	wire req = i_read | i_write;
	wire wr_fire = i_write & ack_reg;
	wire [4:0] addr = i_address[4:0];
	wire [ADDR_W-1:0] addr_hi = i_address >> 5;
	wire hit = (addr_hi == '0) && (addr[1:0] == 2'b00);
	wire wr_c1 = wr_fire && hit && addr == OFS_CONTROL_ONE;
	wire wr_c2 = wr_fire && hit && addr == OFS_CONTROL_TWO;
	wire wr_pl = wr_fire && hit && addr == OFS_POLY_TERMS_LOW;
	wire wr_ph = wr_fire && hit && addr == OFS_POLY_TERMS_HIGH;
	wire wr_dl = wr_fire && hit && addr == OFS_FIFO_IN_LOW;
	wire wr_dh = wr_fire && hit && addr == OFS_FIFO_IN_HIGH;
	wire wr_rl = wr_fire && hit && addr == OFS_RESULT_LOW;
	wire wr_rh = wr_fire && hit && addr == OFS_RESULT_HIGH;
	assign o_waitrequest = req & ~ack_reg;

	// fifo depth and flags from width band
	wire [4:0] depth = (width_sel_reg >= WIDTH_WIDE_MIN) ? DEPTH_WIDE :
		(width_sel_reg >= WIDTH_MID_MIN) ? DEPTH_MID : DEPTH_NARROW; // RL6
	wire full = (count_reg == depth); // RL12
	wire empty = (count_reg == 5'd0); // RL13

	// data entry: merged word and detection of the width's top byte
	wire [15:0] hold_lo_next = wr_dl ? merge16(hold_reg[15:0], i_writedata[15:0],
		i_byteenable[1:0]) : hold_reg[15:0];
	wire [15:0] hold_hi_next = wr_dh ? merge16(hold_reg[31:16], i_writedata[15:0],
		i_byteenable[1:0]) : hold_reg[31:16];
	wire [1:0] top_byte = width_sel_reg[4:3];
	wire top_written = (wr_dl && top_byte == 2'd0 && i_byteenable[0]) ||
		(wr_dl && top_byte == 2'd1 && i_byteenable[1]) ||
		(wr_dh && top_byte == 2'd2 && i_byteenable[0]) ||
		(wr_dh && top_byte == 2'd3 && i_byteenable[1]); // RL8
	wire push = enable_reg && top_written && !full;
	wire [31:0] push_word = {hold_hi_next, hold_lo_next} & low_mask(width_sel_reg); // RL7 RL22

	// engine control
	wire load = enable_reg && start_reg && !busy_reg && !empty; // RL10
	wire hw_done = enable_reg && start_reg && !busy_reg && empty; // RL11
	wire [31:0] fifo_head = fifo_mem[rd_ptr_reg];
	wire [5:0] width_bits = {1'b0, width_sel_reg} + 6'd1; // RL22
	wire [31:0] load_word = lsb_first_reg ? fifo_head :
		(fifo_head << (5'd31 - width_sel_reg)); // RL16
	wire [31:0] taps = ({poly_reg, 1'b1}) & low_mask(poly_length_sel_sel_reg); // RL2 RL3 RL4 RL21
	wire d0 = lsb_first_reg ? shift_reg[0] : shift_reg[31]; // RL16
	wire d1 = lsb_first_reg ? shift_reg[1] : shift_reg[30];
	wire [31:0] step1 = crc_bit(result_reg, d0, taps, poly_length_sel_sel_reg); // RL1 RL17
	wire [31:0] step2 = (left_reg >= BITS_PER_CYCLE) ? crc_bit(step1, d1, taps, poly_length_sel_sel_reg) :
		step1; // RL11
	wire [5:0] left_dec = (left_reg >= BITS_PER_CYCLE) ? left_reg - BITS_PER_CYCLE : 6'd0;
	wire irq_event = irq_sel_reg ? hw_done : (load && count_reg == 5'd1 && !push); // RL18 RL19

	// control_one readback
	wire [15:0] ctrl_one_rd = 16'h0000 | ({15'd0, enable_reg} << BIT_MODULE_ENABLE) |
		({15'd0, idle_stop_reg} << BIT_IDLE_STOP) | ({11'd0, count_reg} << BIT_COUNT_LSB) |
		({15'd0, full} << BIT_FULL) | ({15'd0, empty} << BIT_EMPTY) |
		({15'd0, irq_sel_reg} << BIT_IRQ_SEL) | ({15'd0, start_reg} << BIT_START) |
		({15'd0, lsb_first_reg} << BIT_LSB_FIRST);
	wire [15:0] ctrl_two_rd = ({11'd0, width_sel_reg} << BIT_WIDTH_LSB) |
		({11'd0, poly_length_sel_sel_reg} << BIT_POLY_LENGTH_SEL_LSB);
	wire [15:0] rd_half = !hit ? 16'h0000 :
		addr == OFS_CONTROL_ONE ? ctrl_one_rd :
		addr == OFS_CONTROL_TWO ? ctrl_two_rd :
		addr == OFS_POLY_TERMS_LOW ? {poly_reg[15:1], 1'b0} :
		addr == OFS_POLY_TERMS_HIGH ? poly_reg[31:16] :
		addr == OFS_FIFO_IN_LOW ? hold_reg[15:0] :
		addr == OFS_FIFO_IN_HIGH ? hold_reg[31:16] :
		addr == OFS_RESULT_LOW ? result_reg[15:0] :
		addr == OFS_RESULT_HIGH ? result_reg[31:16] : 16'h0000;
	wire [15:0] c1_w = merge16(ctrl_one_rd, i_writedata[15:0], i_byteenable[1:0]);
	wire [15:0] c2_w = merge16(ctrl_two_rd, i_writedata[15:0], i_byteenable[1:0]);
	wire [15:0] poly_lo_w = merge16({poly_reg[15:1], 1'b0}, i_writedata[15:0],
		i_byteenable[1:0]);

	// bus handshake and read data
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			ack_reg <= 1'b0;
			readdata_reg <= RST_WORD;
		end
		else
		begin
			ack_reg <= req & ~ack_reg;
			if (i_read && !ack_reg)
				readdata_reg <= {16'h0000, rd_half};
		end
	end
	assign o_readdata = readdata_reg;

	// configuration registers survive enable low
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			enable_reg <= 1'b0;
			idle_stop_reg <= 1'b0;
			irq_sel_reg <= 1'b0;
			lsb_first_reg <= 1'b0;
			width_sel_reg <= 5'd0;
			poly_length_sel_sel_reg <= 5'd0;
			poly_reg <= 31'd0;
		end
		else
		begin
			if (wr_c1)
			begin
				enable_reg <= c1_w[BIT_MODULE_ENABLE];
				idle_stop_reg <= c1_w[BIT_IDLE_STOP];
				irq_sel_reg <= c1_w[BIT_IRQ_SEL];
				lsb_first_reg <= c1_w[BIT_LSB_FIRST];
			end
			if (wr_c2)
			begin
				width_sel_reg <= c2_w[BIT_WIDTH_LSB +: 5]; // RL5
				poly_length_sel_sel_reg <= c2_w[BIT_POLY_LENGTH_SEL_LSB +: 5]; // RL1
			end
			if (wr_pl)
				poly_reg[15:1] <= poly_lo_w[15:1]; // RL3
			if (wr_ph)
				poly_reg[31:16] <= merge16(poly_reg[31:16], i_writedata[15:0],
					i_byteenable[1:0]); // RL4
		end
	end

	// fifo, pointers and count
	always_ff @(posedge i_clk)
	begin
		if (i_rst || !enable_reg)
		begin
			wr_ptr_reg <= 4'd0; // RL14 RL23
			rd_ptr_reg <= 4'd0;
			count_reg <= 5'd0;
			hold_reg <= RST_WORD;
		end
		else
		begin
			hold_reg <= {hold_hi_next, hold_lo_next};
			if (push)
			begin
				fifo_mem[wr_ptr_reg] <= push_word;
				wr_ptr_reg <= wr_ptr_reg + 4'd1;
			end
			if (load)
				rd_ptr_reg <= rd_ptr_reg + 4'd1; // RL10
			if (push && !load)
				count_reg <= count_reg + 5'd1; // RL8
			else if (load && !push)
				count_reg <= count_reg - 5'd1; // RL10
		end
	end

	// shift engine; result pair is the working remainder
	always_ff @(posedge i_clk)
	begin
		if (i_rst || !enable_reg)
		begin
			start_reg <= 1'b0; // RL23
			busy_reg <= 1'b0;
			shift_reg <= RST_WORD;
			left_reg <= 6'd0;
			result_reg <= RST_WORD;
			irq_reg <= 1'b0;
		end
		else
		begin
			irq_reg <= irq_event;
			if (wr_c1)
				start_reg <= c1_w[BIT_START];
			else if (hw_done)
				start_reg <= 1'b0; // RL11
			if (load)
			begin
				busy_reg <= 1'b1;
				shift_reg <= load_word;
				left_reg <= width_bits;
			end
			else if (busy_reg)
			begin
				shift_reg <= lsb_first_reg ? shift_reg >> 2 : shift_reg << 2;
				left_reg <= left_dec;
				busy_reg <= (left_dec != 6'd0);
			end
			if (wr_rl || wr_rh)
				result_reg <= {wr_rh ? merge16(result_reg[31:16], i_writedata[15:0],
					i_byteenable[1:0]) : result_reg[31:16], wr_rl ? merge16(result_reg[15:0],
					i_writedata[15:0], i_byteenable[1:0]) : result_reg[15:0]}; // RL24
			else if (busy_reg)
				result_reg <= step2; // RL24
		end
	end
	assign o_crc_irq = irq_reg;

	// checks on the engine and fifo
	AST_COUNT_BOUND: assert property (@(posedge i_clk) disable iff (i_rst)
		count_reg <= depth || $past(wr_c2)) else $error("count above depth"); // RL6
	AST_FULL_FLAG: assert property (@(posedge i_clk) disable iff (i_rst) // RL12
		(push && !load && count_reg == depth - 5'd1) |=> ctrl_one_rd[BIT_FULL])
		else $error("full flag missing");
	AST_EMPTY_FLAG: assert property (@(posedge i_clk) disable iff (i_rst) // RL13
		(load && !push && count_reg == 5'd1) |=> ctrl_one_rd[BIT_EMPTY])
		else $error("empty flag missing");
	AST_DISABLE_FLUSH: assert property (@(posedge i_clk) disable iff (i_rst)
		!enable_reg |=> count_reg == 5'd0 && !busy_reg && result_reg == 32'h0000_0000)
		else $error("disable did not flush"); // RL14
	AST_POP_DEC: assert property (@(posedge i_clk) disable iff (i_rst)
		(load && !push) |=> count_reg == $past(count_reg) - 5'd1 && busy_reg)
		else $error("pop did not decrement"); // RL10
	AST_PUSH_INC: assert property (@(posedge i_clk) disable iff (i_rst)
		(push && !load) |=> count_reg == $past(count_reg) + 5'd1)
		else $error("push did not increment"); // RL8
	AST_WORD_32_TIME: assert property (@(posedge i_clk) disable iff (i_rst || !enable_reg)
		(load && width_sel_reg == 5'd31) |=> busy_reg ##15 busy_reg ##1 !busy_reg)
		else $error("32-bit word not 16 cycles"); // RL11
	AST_AUTO_CLEAR: assert property (@(posedge i_clk) disable iff (i_rst)
		(hw_done && !wr_c1) |=> !start_reg) else $error("start not cleared"); // RL11
	AST_IRQ_EMPTY: assert property (@(posedge i_clk) disable iff (i_rst || !enable_reg)
		(!irq_sel_reg && load && count_reg == 5'd1 && !push) |=> o_crc_irq)
		else $error("no irq on count one to zero"); // RL18
	AST_IRQ_CAUSE: assert property (@(posedge i_clk) disable iff (i_rst)
		o_crc_irq |-> $past(irq_sel_reg) ? $past(hw_done) : $past(load))
		else $error("irq without cause"); // RL19
endmodule // crc_gen

// [tb/tb.sv]
// self-checking bench for the programmable crc generator
// assumes crc_gen on one 50 MHz clock, avalon-mm with one wait cycle per request
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin num_errors++; $display("Error %0t: mismatch got %h exp %h", $time, a, b); end end
module tb
	import crc_gen_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [4:0] address = 5'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [3:0] be = 4'h3;
	logic [31:0] wdata = 32'h0000_0000;
	logic [31:0] rdata;
	logic waitreq;
	logic irq;
	int num_errors = 0;
	int n_compared = 0;
	int irq_cnt = 0;
	crc_gen DUT (.i_clk(clk), .i_rst(rst), .i_address(address), .i_read(read), .i_write(write),
		.i_byteenable(be), .i_writedata(wdata), .o_readdata(rdata), .o_waitrequest(waitreq),
		.o_crc_irq(irq));
	// 50 MHz clock
	initial
	begin
		forever #10 clk = ~clk;
	end
	// count interrupt pulses where the output has settled
	always @(negedge clk)
	begin
		if (irq === 1'b1) irq_cnt++;
	end
	// one bus transfer, held until waitrequest is seen low at a rising edge
	// the leading edge keeps a release and the next request out of one time step
	task automatic xfer(input logic wr, input logic [4:0] a, input logic [15:0] d,
		output logic [31:0] q);
		int k;
		k = 0;
		@(posedge clk);
		address <= a;
		wdata <= {16'h0000, d};
		write <= wr;
		read <= !wr;
		do
		begin
			@(posedge clk);
			k++;
		end while (waitreq !== 1'b0 && k < 50);
		if (waitreq !== 1'b0) num_errors++;
		q = rdata;
		write <= 1'b0;
		read <= 1'b0;
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		xfer(1'b0, a, 16'h0000, q);
		`CHK(q, e)
	endtask
	// bit-serial reference remainder, normal non-reflected form
	function automatic logic [31:0] ref_crc(logic [31:0] r, logic [31:0] p, int n,
		logic [31:0] d, int w, bit lsb);
		logic [31:0] m;
		logic fb;
		m = (n == 32) ? 32'hFFFF_FFFF : ((32'h0000_0001 << n) - 32'h0000_0001);
		for (int i = 0; i < w; i++)
		begin
			fb = r[n-1] ^ (lsb ? d[i] : d[w-1-i]);
			r = ((r << 1) & m) ^ (fb ? ((p | 32'h0000_0001) & m) : 32'h0000_0000);
		end
		return r;
	endfunction
	// poll until hardware drops start, bounded
	task automatic wait_done();
		logic [31:0] q;
		int k;
		k = 0;
		do
		begin
			xfer(1'b0, OFS_CONTROL_ONE, 16'h0000, q);
			k++;
		end while (q[BIT_START] === 1'b1 && k < 200);
		`CHK(q[BIT_START], 1'b0)
	endtask
	// 16-bit poly, byte words, msb first, fifo filled to refusal
	task automatic test_narrow();
		logic [31:0] r;
		r = 32'h0000_FFFF;
		wr(OFS_CONTROL_ONE, 16'h8000);
		wr(OFS_CONTROL_TWO, 16'h070F);
		wr(OFS_POLY_TERMS_LOW, 16'h1021);
		wr(OFS_POLY_TERMS_HIGH, 16'h0000);
		rd_chk(OFS_POLY_TERMS_LOW, 32'h0000_1020);
		wr(OFS_RESULT_LOW, 16'hFFFF);
		wr(OFS_RESULT_HIGH, 16'h0000);
		for (int i = 0; i < 17; i++)
		begin
			wr(OFS_FIFO_IN_LOW, {8'hA0, 8'(i * 17 + 3)});
			if (i < 16) r = ref_crc(r, 32'h0000_1021, 16, 32'(8'(i * 17 + 3)), 8, 1'b0);
			if (i == 14) rd_chk(OFS_CONTROL_ONE, 32'h0000_8F00);
		end
		rd_chk(OFS_CONTROL_ONE, 32'h0000_9080);
		wr(OFS_CONTROL_ONE, 16'h8010);
		wait_done();
		rd_chk(OFS_CONTROL_ONE, 32'h0000_8040);
		rd_chk(OFS_RESULT_LOW, {16'h0000, r[15:0]});
		`CHK(irq_cnt, 1)
	endtask
	// 32-bit poly, 32-bit words, lsb first, interrupt on hardware start clear
	task automatic test_wide();
		logic [31:0] r;
		logic [31:0] w;
		r = 32'hFFFF_FFFF;
		wr(OFS_CONTROL_ONE, 16'h8028);
		wr(OFS_CONTROL_TWO, 16'h1F1F);
		wr(OFS_POLY_TERMS_LOW, 16'h1DB7);
		wr(OFS_POLY_TERMS_HIGH, 16'h04C1);
		wr(OFS_RESULT_LOW, 16'hFFFF);
		wr(OFS_RESULT_HIGH, 16'hFFFF);
		for (int i = 0; i < 4; i++)
		begin
			w = {16'h1357 + 16'(i), 16'h2468 ^ 16'(i)};
			wr(OFS_FIFO_IN_LOW, w[15:0]);
			if (i == 0) rd_chk(OFS_CONTROL_ONE, 32'h0000_8068);
			wr(OFS_FIFO_IN_HIGH, w[31:16]);
			r = ref_crc(r, 32'h04C1_1DB7, 32, w, 32, 1'b1);
		end
		rd_chk(OFS_CONTROL_ONE, 32'h0000_84A8);
		wr(OFS_CONTROL_ONE, 16'h8038);
		wait_done();
		rd_chk(OFS_RESULT_LOW, {16'h0000, r[15:0]});
		rd_chk(OFS_RESULT_HIGH, {16'h0000, r[31:16]});
		`CHK(irq_cnt, 2)
	endtask
	// disable clears fifo and result but keeps configuration
	task automatic test_disable();
		wr(OFS_FIFO_IN_LOW, 16'h1111);
		wr(OFS_FIFO_IN_HIGH, 16'h2222);
		wr(OFS_CONTROL_ONE, 16'h0028);
		rd_chk(OFS_CONTROL_ONE, 32'h0000_0068);
		rd_chk(OFS_RESULT_LOW, 32'h0000_0000);
		rd_chk(OFS_CONTROL_TWO, 32'h0000_1F1F);
		rd_chk(5'h02, 32'h0000_0000);
		`CHK(irq_cnt, 2)
	endtask
	task automatic summarize();
		if (num_errors == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// main sequence
	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		rd_chk(OFS_CONTROL_ONE, 32'h0000_0040);
		test_narrow();
		test_wide();
		test_disable();
		summarize();
	end
	// watchdog against a hung handshake or engine
	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		summarize();
	end
endmodule // tb
